// ===== design/ddsil_regs.svh
// Constants for the dual converter serial input logic and its host.
// Included by the package and by both ends; definitions only.
`ifndef DDSIL_REGS_SVH
`define DDSIL_REGS_SVH

// Word layout
`define DDSIL_CODE_W      12
`define DDSIL_FRAME_W     16
`define DDSIL_CNT_W       5
`define DDSIL_ZERO_CODE   12'h000
`define DDSIL_HALF_CODE   12'h800

// Host register map, byte addresses
`define DDSIL_ADDR_W      4
`define DDSIL_OFF_CTRL    4'h0
`define DDSIL_OFF_DATA    4'h4
`define DDSIL_OFF_STATUS  4'h8
`define DDSIL_OFF_LOAD    4'hc

// Control register fields
`define DDSIL_CTRL_W      5
`define DDSIL_CTRL_PWR_ON 0
`define DDSIL_CTRL_HALF   1
`define DDSIL_CTRL_PRESET 2
`define DDSIL_CTRL_AUTO_A 3
`define DDSIL_CTRL_AUTO_B 4
`define DDSIL_CTRL_RESET  5'h01

// Status and load fields
`define DDSIL_STAT_BUSY   0
`define DDSIL_STAT_PRESET 1
`define DDSIL_LOAD_A      0
`define DDSIL_LOAD_B      1

// Timing in ns and in host clock cycles (5 ns each)
`define DDSIL_CLK_NS      5
`define DDSIL_HALF_NS     25
`define DDSIL_HALF_CYC    ((`DDSIL_HALF_NS + `DDSIL_CLK_NS - 1) / `DDSIL_CLK_NS)
`define DDSIL_LOAD_NS     20
`define DDSIL_LOAD_CYC    ((`DDSIL_LOAD_NS + `DDSIL_CLK_NS - 1) / `DDSIL_CLK_NS)

`endif

// ===== design/ddsil_pkg.sv
// Types shared by the host end of the serial converter link.
// Assumes ddsil_regs.svh is on the include path.
`include "ddsil_regs.svh"

package ddsil_pkg;

	typedef logic [`DDSIL_CODE_W-1:0] ddsil_code_t;

	typedef enum logic [2:0] {
		DDSIL_IDLE  = 3'b001,
		DDSIL_SHIFT = 3'b010,
		DDSIL_LOAD  = 3'b100
	} ddsil_state_t;

endpackage

// ===== design/ddsil_if.sv
// Pin bundle between the converter front end and its host.
// Host drives every pin; the serial clock runs only inside frames.
`timescale 1ns/1ps

interface ddsil_if;
	logic sclk;
	logic serial_data_in;
	logic chip_select_n;
	logic load_strobe_a_n;
	logic load_strobe_b_n;
	logic force_preset_n;
	logic preset_half_scale;
	logic power_down_n;

	modport host (
		output sclk,
		output serial_data_in,
		output chip_select_n,
		output load_strobe_a_n,
		output load_strobe_b_n,
		output force_preset_n,
		output preset_half_scale,
		output power_down_n
	);

	modport dev (
		input sclk,
		input serial_data_in,
		input chip_select_n,
		input load_strobe_a_n,
		input load_strobe_b_n,
		input force_preset_n,
		input preset_half_scale,
		input power_down_n
	);
endinterface

// ===== design/ddsil_dev.sv
// Converter end: serial input register and the two converter registers.
// Clocked only by the link clock; strobes and preset act without a clock.
//
// Function
// - Sample data on each enabled rising edge
// - Words travel top bit first
// - Host sends sixteen clocks per code
// - Only last twelve bits are kept
// - Clock ignored while chip select high
// - Sixteen-bit frame: four pad bits first
// - Shift register separate from converter registers
// - Low strobe copies shift register, asynchronously
// - Host raises strobes before shifting new data
// - Preset low, select zero: all zeros
// - Preset low, select one: half scale
// - Preset overrides both load strobes
// - Strobe still low at release copies
// - Host raises strobes before releasing preset
// - Power-down low turns analog outputs off
// - Register values kept through shutdown
// - Logic stays active during shutdown
// - Preset asynchronous, applies to both channels
`timescale 1ns/1ps
`include "ddsil_regs.svh"

module ddsil_dev
	import ddsil_pkg::*;
#(
	parameter int unsigned CODE_W = `DDSIL_CODE_W,
	parameter int unsigned CNT_W  = `DDSIL_CNT_W
) (
	// Link pins from the host
	ddsil_if.dev                link,
	// Converter register contents
	output logic [CODE_W-1:0]   code_a_o,
	output logic [CODE_W-1:0]   code_b_o,
	// Codes seen by the analog outputs
	output logic [CODE_W-1:0]   out_a_o,
	output logic [CODE_W-1:0]   out_b_o,
	// Analog section state
	output logic                analog_on_o,
	output logic                preset_active_o,
	// Serial input observation
	output logic [CODE_W-1:0]   shift_word_o,
	output logic [CNT_W-1:0]    frame_bits_o,
	output logic                word_complete_o
);

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CODE_W);

	logic [CODE_W-1:0] shift_r;
	logic [CNT_W-1:0]  bits_r;
	logic [CODE_W-1:0] conv_r [2];
	logic [1:0]        load_n;
	logic [CODE_W-1:0] preset_code;

	// Serial input register
	// Gated by chip select rather than synchronised: the pins are
	// launched by the host around this very clock, so the edge is the
	// sampling point and no extra flops may sit in front.
	always_ff @(posedge link.sclk) begin
		if (!link.chip_select_n) begin
			shift_r <= {shift_r[CODE_W-2:0], link.serial_data_in};
		end
	end

	// Bits seen in the current frame
	// Cleared by chip select itself, since the link clock stops
	// between frames and no edge is left to clear it.
	always_ff @(posedge link.sclk or posedge link.chip_select_n) begin
		if (link.chip_select_n) begin
			bits_r <= '0;
		end else if (bits_r != CNT_MAX) begin
			bits_r <= bits_r + 1'b1;
		end
	end

	// Preset level chosen by the select pin
	always_comb begin
		if (link.preset_half_scale) begin
			preset_code = `DDSIL_HALF_CODE;
		end else begin
			preset_code = `DDSIL_ZERO_CODE;
		end
	end

	assign load_n = {link.load_strobe_b_n, link.load_strobe_a_n};

	// Converter registers
	// Transparent latches: a low strobe keeps the register following
	// the shift register, and the preset wins over it while low. On
	// the release of preset a strobe still low takes over at once.
	for (genvar g = 0; g < 2; g++) begin : g_chan
		always_latch begin
			if (!link.force_preset_n) begin
				conv_r[g] <= preset_code;
			end else if (!load_n[g]) begin
				conv_r[g] <= shift_r;
			end
		end
	end

	// Register contents stay put in shutdown; only the outputs drop
	assign code_a_o = conv_r[0];
	assign code_b_o = conv_r[1];

	// Shutdown forces the analog outputs to zero volts
	assign analog_on_o = link.power_down_n;
	assign out_a_o = link.power_down_n ? conv_r[0] : `DDSIL_ZERO_CODE;
	assign out_b_o = link.power_down_n ? conv_r[1] : `DDSIL_ZERO_CODE;

	assign preset_active_o = !link.force_preset_n;

	// Observation of the serial side
	assign shift_word_o    = shift_r;
	assign frame_bits_o    = bits_r;
	assign word_complete_o = (bits_r >= CNT_FULL);

endmodule

// ===== design/ddsil_host.sv
// Host end: turns register writes into serial frames and load strobes.
// Runs on clock_i; the link clock is divided down from it and driven out.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ddsil_regs.svh"

module ddsil_host
	import ddsil_pkg::*;
#(
	parameter int unsigned HALF_CYC = `DDSIL_HALF_CYC,
	parameter int unsigned LOAD_CYC = `DDSIL_LOAD_CYC
) (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     srst_i,
	// Register port
	input  wire logic [`DDSIL_ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]              reg_wdata_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	output logic      [31:0]              reg_rdata_o,
	// Link pins to the converter
	ddsil_if.host                         link
);

	localparam int unsigned FW = `DDSIL_FRAME_W;

	function automatic logic hit(input logic [`DDSIL_ADDR_W-1:0] a,
	                             input logic [`DDSIL_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	ddsil_state_t             state_r;
	logic [`DDSIL_CTRL_W-1:0] ctrl_r;
	ddsil_code_t              code_r;
	logic [FW-1:0]            frame_r;
	logic [4:0]               left_r;
	logic [15:0]              div_r;
	logic [1:0]               sel_r;
	logic                     tick;
	logic                     wr_data;
	logic                     wr_load;

	logic sclk_r, sdi_r, cs_n_r, lda_n_r, ldb_n_r, preset_n_r, half_r, pwr_r;

	assign tick    = (div_r == 16'(HALF_CYC - 1));
	assign wr_data = reg_wr_i && hit(reg_addr_i, `DDSIL_OFF_DATA);
	assign wr_load = reg_wr_i && hit(reg_addr_i, `DDSIL_OFF_LOAD);

	// Control register
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ctrl_r <= `DDSIL_CTRL_RESET;
		end else if (reg_wr_i && hit(reg_addr_i, `DDSIL_OFF_CTRL)) begin
			ctrl_r <= reg_wdata_i[`DDSIL_CTRL_W-1:0];
		end
	end

	// Static pins follow the control register
	// Preset is only released with both strobes high, so the preset
	// values survive the release.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pwr_r      <= 1'b1;
			half_r     <= 1'b0;
			preset_n_r <= 1'b1;
		end else begin
			pwr_r  <= ctrl_r[`DDSIL_CTRL_PWR_ON];
			half_r <= ctrl_r[`DDSIL_CTRL_HALF];
			if (ctrl_r[`DDSIL_CTRL_PRESET]) begin
				preset_n_r <= 1'b0;
			end else if (state_r == DDSIL_IDLE && !wr_load) begin
				// Idle only: a frame or load write could drop a strobe
				// in the very cycle that preset rises.
				preset_n_r <= 1'b1;
			end
		end
	end

	// Divider for the link clock and strobe width
	always_ff @(posedge clock_i) begin
		if (srst_i || state_r == DDSIL_IDLE || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	// Frame and strobe sequencer
	// Data and load writes while busy are dropped; software polls the busy bit.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_r <= DDSIL_IDLE;
			sclk_r  <= 1'b0;
			sdi_r   <= 1'b0;
			cs_n_r  <= 1'b1;
			lda_n_r <= 1'b1;
			ldb_n_r <= 1'b1;
			frame_r <= '0;
			left_r  <= '0;
			sel_r   <= '0;
			code_r  <= '0;
		end else begin
			case (state_r)
				DDSIL_IDLE: begin
					if (wr_data) begin
						code_r  <= reg_wdata_i[`DDSIL_CODE_W-1:0];
						frame_r <= {4'h0, reg_wdata_i[`DDSIL_CODE_W-1:0]};
						sdi_r   <= 1'b0;
						cs_n_r  <= 1'b0;
						left_r  <= 5'(FW);
						sel_r   <= {ctrl_r[`DDSIL_CTRL_AUTO_B], ctrl_r[`DDSIL_CTRL_AUTO_A]};
						state_r <= DDSIL_SHIFT;
					end else if (wr_load && reg_wdata_i[1:0] != 2'h0) begin
						lda_n_r <= !reg_wdata_i[`DDSIL_LOAD_A];
						ldb_n_r <= !reg_wdata_i[`DDSIL_LOAD_B];
						state_r <= DDSIL_LOAD;
					end
				end
				DDSIL_SHIFT: begin
					if (tick && !sclk_r) begin
						sclk_r <= 1'b1;
						left_r <= left_r - 5'h01;
					end else if (tick) begin
						sclk_r <= 1'b0;
						if (left_r == 5'h00) begin
							cs_n_r <= 1'b1;
							if (sel_r != 2'h0) begin
								lda_n_r <= !sel_r[0];
								ldb_n_r <= !sel_r[1];
								state_r <= DDSIL_LOAD;
							end else begin
								state_r <= DDSIL_IDLE;
							end
						end else begin
							frame_r <= {frame_r[FW-2:0], 1'b0};
							sdi_r   <= frame_r[FW-2];
						end
					end else if (left_r == 5'(FW)) begin
						sdi_r <= frame_r[FW-1];
					end
				end
				DDSIL_LOAD: begin
					if (div_r == 16'(LOAD_CYC - 1)) begin
						lda_n_r <= 1'b1;
						ldb_n_r <= 1'b1;
						state_r <= DDSIL_IDLE;
					end
				end
				default: begin
					state_r <= DDSIL_IDLE;
				end
			endcase
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (srst_i || !reg_rd_i) begin
			reg_rdata_o <= '0;
		end else if (hit(reg_addr_i, `DDSIL_OFF_CTRL)) begin
			reg_rdata_o <= 32'(ctrl_r);
		end else if (hit(reg_addr_i, `DDSIL_OFF_DATA)) begin
			reg_rdata_o <= 32'(code_r);
		end else if (hit(reg_addr_i, `DDSIL_OFF_STATUS)) begin
			reg_rdata_o <= {30'h0, !preset_n_r, state_r != DDSIL_IDLE};
		end else begin
			reg_rdata_o <= '0;
		end
	end

	assign link.sclk              = sclk_r;
	assign link.serial_data_in    = sdi_r;
	assign link.chip_select_n     = cs_n_r;
	assign link.load_strobe_a_n   = lda_n_r;
	assign link.load_strobe_b_n   = ldb_n_r;
	assign link.force_preset_n    = preset_n_r;
	assign link.preset_half_scale = half_r;
	assign link.power_down_n      = pwr_r;

endmodule

// ===== sim/ddsil_link_properties.sv
// Link checks on the pins that the host end drives.
// Assumes host clock domain; link pins come straight from host flops.
`timescale 1ns/1ps

module ddsil_link_properties (
	// Host clock domain
	input wire logic clock_i,
	input wire logic srst_i,
	// Link pins
	input wire logic sclk,
	input wire logic serial_data_in,
	input wire logic chip_select_n,
	input wire logic load_strobe_a_n,
	input wire logic load_strobe_b_n,
	input wire logic force_preset_n,
	input wire logic preset_half_scale,
	input wire logic power_down_n
);
	logic       sclk_q_r;
	logic [4:0] bits_r;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	always_ff @(posedge clock_i) begin
		sclk_q_r <= sclk;
	end

	// Rises in the current frame; cleared between frames
	always_ff @(posedge clock_i) begin
		if (srst_i || chip_select_n) begin
			bits_r <= 5'h00;
		end else if (sclk && !sclk_q_r) begin
			bits_r <= bits_r + 5'h01;
		end
	end

	property p_idle_clock;
		chip_select_n |-> !sclk;
	endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("clock outside frame");

	property p_frame_len;
		$rose(chip_select_n) |-> bits_r == 5'h10;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

	property p_pad_bits;
		(sclk && !sclk_q_r && bits_r < 5'h04) |-> !serial_data_in;
	endproperty
	a_pad_bits: assert property (p_pad_bits) else $error("pad bit not zero");

	property p_data_stable;
		sclk |-> $stable(serial_data_in);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved");

	property p_sclk_high;
		$rose(sclk) |-> sclk[*5] ##1 !sclk;
	endproperty
	a_sclk_high: assert property (p_sclk_high) else $error("clock high phase");

	property p_strobe_frame;
		!chip_select_n |-> load_strobe_a_n && load_strobe_b_n;
	endproperty
	a_strobe_frame: assert property (p_strobe_frame) else $error("strobe in frame");

	property p_preset_release;
		$rose(force_preset_n) |-> load_strobe_a_n && load_strobe_b_n;
	endproperty
	a_preset_release: assert property (p_preset_release) else $error("strobe low");

	property p_strobe_len;
		$fell(load_strobe_a_n) |-> !load_strobe_a_n[*4] ##1 load_strobe_a_n;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
endmodule

// ===== sim/test_dual_dac_serial_input_logic.sv
// Self-checking bench: host and converter end on one link, plus a
// second converter end driven by the bench. Design folder on include path.
`timescale 1ns/1ps
`include "ddsil_regs.svh"

module test_dual_dac_serial_input_logic;
	logic        clock_i;
	logic        srst_i;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic [11:0] code_a, code_b, out_a, out_b, shift_w, code_a2, code_b2, shift_w2;
	logic        analog_on;
	logic [4:0]  fbits2;
	logic        wc2;
	logic        pa2;
	int          miscompares;
	int          cmp_count;
	logic [31:0] rd_v;

	ddsil_if link ();
	ddsil_if link2 ();

	ddsil_host u_ddsil_host (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .link(link));
	ddsil_dev u_ddsil_dev (.link(link), .code_a_o(code_a), .code_b_o(code_b),
		.out_a_o(out_a), .out_b_o(out_b), .analog_on_o(analog_on), .preset_active_o(),
		.shift_word_o(shift_w), .frame_bits_o(), .word_complete_o());
	// Far end fed by the bench, for faults of the host side
	ddsil_dev u_ddsil_dev_far (.link(link2), .code_a_o(code_a2), .code_b_o(code_b2),
		.out_a_o(), .out_b_o(), .analog_on_o(), .preset_active_o(pa2),
		.shift_word_o(shift_w2), .frame_bits_o(fbits2), .word_complete_o(wc2));
	ddsil_link_properties u_props (.clock_i(clock_i), .srst_i(srst_i), .sclk(link.sclk),
		.serial_data_in(link.serial_data_in), .chip_select_n(link.chip_select_n),
		.load_strobe_a_n(link.load_strobe_a_n), .load_strobe_b_n(link.load_strobe_b_n),
		.force_preset_n(link.force_preset_n), .preset_half_scale(link.preset_half_scale),
		.power_down_n(link.power_down_n));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 rd_v = reg_rdata_o;
	endtask

	task automatic settle();
		repeat (2) @(posedge clock_i);
		#1;
	endtask

	task automatic wait_idle();
		rd(`DDSIL_OFF_STATUS);
		repeat (200) if (rd_v[`DDSIL_STAT_BUSY] !== 1'b0) rd(`DDSIL_OFF_STATUS);
		chk("busy", 32'h0, rd_v);
	endtask

	// One bit at the bench-made 48 ns link clock
	task automatic lbit(input logic b);
		link2.serial_data_in = b;
		#24 link2.sclk = 1'b1;
		#24 link2.sclk = 1'b0;
	endtask

	task automatic t_regs();
		rd(`DDSIL_OFF_CTRL);
		chk("ctrl", 32'h1, rd_v);
		rd(`DDSIL_OFF_STATUS);
		chk("status", 32'h0, rd_v);
		rd(4'h2);
		chk("unmapped", 32'h0, rd_v);
		chk("analog on", 32'h1, 32'(analog_on));
	endtask

	task automatic t_preset();
		wr(`DDSIL_OFF_CTRL, 32'h05);
		settle();
		chk("zero a", 32'h0, 32'(code_a));
		chk("zero b", 32'h0, 32'(code_b));
		rd(`DDSIL_OFF_STATUS);
		chk("status preset", 32'h2, rd_v);
		wr(`DDSIL_OFF_CTRL, 32'h07);
		settle();
		chk("half a", 32'h800, 32'(code_a));
		chk("half b", 32'h800, 32'(code_b));
		wr(`DDSIL_OFF_CTRL, 32'h03);
		settle();
		chk("kept a", 32'h800, 32'(code_a));
	endtask

	task automatic t_frame();
		wr(`DDSIL_OFF_CTRL, 32'h0b);
		wr(`DDSIL_OFF_DATA, 32'habc);
		wr(`DDSIL_OFF_DATA, 32'h123);
		wait_idle();
		chk("code a", 32'habc, 32'(code_a));
		chk("shift", 32'habc, 32'(shift_w));
		chk("code b", 32'h800, 32'(code_b));
		rd(`DDSIL_OFF_DATA);
		chk("data kept", 32'habc, rd_v);
		wr(`DDSIL_OFF_LOAD, 32'h2);
		wait_idle();
		chk("load b", 32'habc, 32'(code_b));
		wr(`DDSIL_OFF_CTRL, 32'h01);
		wr(`DDSIL_OFF_DATA, 32'h5a5);
		wait_idle();
		chk("shift new", 32'h5a5, 32'(shift_w));
		chk("held a", 32'habc, 32'(code_a));
	endtask

	task automatic t_shutdown();
		wr(`DDSIL_OFF_CTRL, 32'h00);
		settle();
		chk("analog off", 32'h0, 32'(analog_on));
		chk("out a off", 32'h0, 32'(out_a));
		wr(`DDSIL_OFF_DATA, 32'h321);
		wait_idle();
		wr(`DDSIL_OFF_LOAD, 32'h1);
		wait_idle();
		chk("load asleep", 32'h321, 32'(code_a));
		wr(`DDSIL_OFF_CTRL, 32'h01);
		settle();
		chk("out a back", 32'h321, 32'(out_a));
		chk("out b back", 32'habc, 32'(out_b));
	endtask

	task automatic t_far();
		logic [13:0] w;
		w = 14'h39c3;
		#7 link2.load_strobe_a_n = 1'b0;
		#10 chk("far preset", 32'h800, 32'(code_a2));
		chk("far preset pin", 32'h1, 32'(pa2));
		link2.chip_select_n = 1'b0;
		for (int i = 13; i >= 0; i--) lbit(w[i]);
		chk("far shift", 32'h9c3, 32'(shift_w2));
		chk("far bits", 32'he, 32'(fbits2));
		chk("far complete", 32'h1, 32'(wc2));
		chk("far held", 32'h800, 32'(code_a2));
		link2.force_preset_n = 1'b1;
		#1 chk("far release", 32'h9c3, 32'(code_a2));
		chk("far b", 32'h800, 32'(code_b2));
		link2.load_strobe_a_n = 1'b1;
		link2.chip_select_n = 1'b1;
		repeat (3) lbit(1'b1);
		link2.serial_data_in = 1'b0;
		chk("far ignored", 32'h9c3, 32'(shift_w2));
		chk("far bits idle", 32'h0, 32'(fbits2));
		link2.preset_half_scale = 1'b0;
		link2.force_preset_n = 1'b0;
		#1 chk("far zero", 32'h0, 32'(code_b2));
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		final_report();
	end

	initial begin
		miscompares = 0;
		cmp_count = 0;
		srst_i = 1'b1;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		{link2.sclk, link2.serial_data_in, link2.chip_select_n} = 3'b001;
		{link2.load_strobe_a_n, link2.load_strobe_b_n, link2.force_preset_n} = 3'b110;
		{link2.preset_half_scale, link2.power_down_n} = 2'b11;
		repeat (3) @(posedge clock_i);
		srst_i <= 1'b0;
		t_regs();
		t_preset();
		t_frame();
		t_shutdown();
		t_far();
		final_report();
	end
endmodule
